// ==== include/lprs_pkg.sv ====
// Contract
// RULE1 - role swap opcode 0x000B, address, role
// RULE2 - role byte 0x00 master, 0x01 slave
// RULE3 - host names only connected peers
// RULE4 - accepted role swap gets status event
// RULE5 - role change event to both hosts
// RULE6 - role swap never gets complete event
// RULE7 - policy read 0x000C returns status, id, word
// RULE8 - policy write 0x000D stores word, returns status
// RULE9 - ids 12 bits, 0x0F00 upward reserved
// RULE10 - bits enable switch, hold, sniff, park
// RULE11 - zero disables all, default per connection
// RULE12 - bits 0x0010 to 0x8000 carry nothing
// RULE13 - each policy bit acts independently
// RULE14 - link manager obeys policy bits
// RULE15 - new word governs only later requests
// RULE16 - host names only acl connections
// RULE17 - status zero success, else error code
// RULE18 - policy read answered by complete event
// RULE19 - policy write answered by complete event
// RULE20 - returned id echoes supplied id
package lprs_pkg;
  // -------------------------------------------
  // command opcode fields
  // -------------------------------------------
  localparam logic [9:0] OCF_SWAP = 10'h00b;
  localparam logic [9:0] OCF_PRD = 10'h00c;
  localparam logic [9:0] OCF_PWR = 10'h00d;
  localparam logic [11:0] HDL_RSVD = 12'hf00; // first reserved id
  localparam logic [7:0] ROLE_MASTER = 8'h00;
  localparam logic [7:0] ROLE_SLAVE = 8'h01;
  localparam logic [7:0] ST_OK = 8'h00;
  // -------------------------------------------
  // policy word layout
  // -------------------------------------------
  localparam logic [15:0] POL_NONE = 16'h0000; // reset default
  localparam logic [15:0] POL_SWITCH = 16'h0001;
  localparam logic [15:0] POL_HOLD = 16'h0002;
  localparam logic [15:0] POL_SNIFF = 16'h0004;
  localparam logic [15:0] POL_PARK = 16'h0008;
  localparam logic [15:0] POL_USED = 16'h000f; // all mode bits
  // -------------------------------------------
  // register port map
  // -------------------------------------------
  localparam logic [3:0] REG_ERR_ID = 4'h0; // code for bad id
  localparam logic [3:0] REG_ERR_CMD = 4'h1; // code for bad opcode
  localparam logic [3:0] REG_ERR_BUSY = 4'h2; // code for busy swap
  localparam logic [3:0] REG_STATE = 4'h3; // pending swap, conns
  localparam logic [7:0] ERR_ID_RST = 8'h02;
  localparam logic [7:0] ERR_CMD_RST = 8'h01;
  localparam logic [7:0] ERR_BUSY_RST = 8'h0c;
  // -------------------------------------------
  // carriers and states
  // -------------------------------------------
  typedef struct packed {
    logic [9:0] command_opcode_field; // command opcode field
    logic [11:0] hdl; // connection id
    logic [47:0] addr; // peer device address
    logic [7:0] role; // requested role
    logic [15:0] pol; // new policy word
  } lprs_cmd_s;
  typedef enum logic [2:0] {
    EV_STATUS = 3'b001,
    EV_CMPL = 3'b010,
    EV_ROLE = 3'b100
  } lprs_kind_e;
  typedef struct packed {
    lprs_kind_e kind; // event type
    logic [9:0] command_opcode_field; // opcode answered
    logic [7:0] status; // zero is success
    logic [11:0] hdl; // echoed id
    logic [15:0] pol; // policy word read
    logic [47:0] addr; // peer of role change
    logic [7:0] role; // new role
  } lprs_evt_s;
  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_WAIT = 2'b10
  } lprs_rs_e;
endpackage

// ==== src/lprs_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module lprs_top import lprs_pkg::*; #(
  parameter int NCONN = 4 // connection slots
) (
  input wire logic CLK, // 100 MHz clock
  input wire logic SYS_RST, // sync reset, high
  input wire logic CMD_VALID, // host command present
  input wire lprs_cmd_s CMD, // command fields
  output logic CMD_READY, // command taken
  output logic EVT_VALID, // one-cycle event
  output lprs_evt_s EVT, // event fields
  input wire logic [NCONN-1:0] LM_CONN_UP, // acl link up per slot
  output logic LM_SW_REQ, // role swap request pulse
  output logic [47:0] LM_SW_ADDR, // peer to swap with
  output logic [7:0] LM_SW_ROLE, // role asked for
  input wire logic LM_SW_DONE, // swap finished pulse
  input wire logic [7:0] LM_SW_STATUS, // swap outcome
  input wire logic [7:0] LM_SW_NEWROLE, // role now held
  output logic RMT_NOTIFY, // tell remote host too
  input wire logic LM_QRY_VALID, // policy query pulse
  input wire logic [11:0] LM_QRY_HDL, // queried id
  input wire logic [3:0] LM_QRY_MODE, // one mode bit
  output logic LM_QRY_DONE, // answer pulse
  output logic LM_QRY_ALLOW, // mode permitted
  input wire logic [3:0] REG_ADDR, // register index
  input wire logic [31:0] REG_WDATA, // write data
  input wire logic REG_WR, // write strobe
  input wire logic REG_RD, // read strobe
  output logic [31:0] REG_RDATA // read data, next cycle
);
  // -------------------------------------------
  // state
  // -------------------------------------------
  logic [3:0] pol_tab [NCONN]; // stored mode bits per slot
  logic [7:0] err_id; // code for unknown id
  logic [7:0] err_cmd; // code for unknown opcode
  logic [7:0] err_busy; // code for second swap
  lprs_rs_e rs_state; // role swap tracker
  logic rc_pend; // role change waiting
  lprs_evt_s rc_evt; // held role change
  logic take; // command accepted now
  logic slot_ok; // id names a live slot
  logic [3:0] slot_pol; // policy of that slot
  lprs_evt_s next_evt; // event to emit
  logic next_evt_v; // event valid

  // role change waiting blocks commands, so it is never starved
  assign CMD_READY = !rc_pend;
  assign take = CMD_VALID && CMD_READY;

  // -------------------------------------------
  // id lookup
  // -------------------------------------------
  // reserved ids and ids past the table are refused
  always_comb begin
    slot_ok = 1'b0;
    slot_pol = 4'h0;
    if (CMD.hdl < HDL_RSVD && CMD.hdl < 12'(NCONN)) begin // see RULE9
      slot_ok = LM_CONN_UP[CMD.hdl[$clog2(NCONN)-1:0]]; // see RULE16
      slot_pol = pol_tab[CMD.hdl[$clog2(NCONN)-1:0]];
    end
  end

  // -------------------------------------------
  // policy storage
  // -------------------------------------------
  // only the four mode bits are stored, reserved bits read zero
  for (genvar i = 0; i < NCONN; i++) begin : g_pol
    always_ff @(posedge CLK) begin
      if (SYS_RST || !LM_CONN_UP[i]) begin
        pol_tab[i] <= POL_NONE[3:0]; // see RULE11
      end else if (take && CMD.command_opcode_field == OCF_PWR && slot_ok &&
                   CMD.hdl[$clog2(NCONN)-1:0] == i) begin
        pol_tab[i] <= CMD.pol[3:0]; // see RULE8 RULE12
      end
    end
  end

  // -------------------------------------------
  // command decode into one event
  // -------------------------------------------
  always_comb begin
    next_evt = '0;
    next_evt.kind = EV_STATUS;
    next_evt.command_opcode_field = CMD.command_opcode_field;
    next_evt.hdl = CMD.hdl; // see RULE20
    next_evt_v = 1'b0;
    if (rc_pend) begin
      next_evt = rc_evt;
      next_evt_v = 1'b1;
    end else if (take) begin
      next_evt_v = 1'b1;
      case (CMD.command_opcode_field)
        OCF_SWAP: begin
          // status only; completion is the later role change
          next_evt.kind = EV_STATUS; // see RULE4 RULE6
          next_evt.status = (rs_state == RS_WAIT) ? err_busy : ST_OK;
        end
        OCF_PRD: begin
          next_evt.kind = EV_CMPL; // see RULE18
          next_evt.status = slot_ok ? ST_OK : err_id; // see RULE17
          next_evt.pol = slot_ok ? {12'h000, slot_pol} : POL_NONE; // see RULE7
        end
        OCF_PWR: begin
          next_evt.kind = EV_CMPL; // see RULE19
          next_evt.status = slot_ok ? ST_OK : err_id; // see RULE17
        end
        default: begin
          next_evt.kind = EV_STATUS;
          next_evt.status = err_cmd;
        end
      endcase
    end
  end

  // event register, data from flip-flops
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      EVT_VALID <= 1'b0;
      EVT <= '0;
    end else begin
      EVT_VALID <= next_evt_v;
      EVT <= next_evt;
    end
  end

  // remote host learns of the change in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RMT_NOTIFY <= 1'b0;
    end else begin
      RMT_NOTIFY <= rc_pend; // see RULE5
    end
  end

  // -------------------------------------------
  // role swap tracking
  // -------------------------------------------
  // one swap in flight; a second is refused with the busy code
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rs_state <= RS_IDLE;
      LM_SW_REQ <= 1'b0;
      LM_SW_ADDR <= '0;
      LM_SW_ROLE <= ROLE_MASTER;
    end else begin
      LM_SW_REQ <= 1'b0;
      case (rs_state)
        RS_IDLE: begin
          if (take && CMD.command_opcode_field == OCF_SWAP) begin // see RULE1 RULE3
            rs_state <= RS_WAIT;
            LM_SW_REQ <= 1'b1;
            LM_SW_ADDR <= CMD.addr;
            // any nonzero role byte asks for the slave side
            LM_SW_ROLE <= (CMD.role == ROLE_MASTER) ? ROLE_MASTER : ROLE_SLAVE; // see RULE2
          end
        end
        RS_WAIT: begin
          if (LM_SW_DONE) begin
            rs_state <= RS_IDLE;
          end
        end
        default: begin
          rs_state <= RS_IDLE;
        end
      endcase
    end
  end

  // role change is held one cycle, then takes the event port ahead of commands
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rc_pend <= 1'b0;
      rc_evt <= '0;
    end else if (LM_SW_DONE && rs_state == RS_WAIT) begin
      rc_pend <= 1'b1; // see RULE5
      rc_evt.kind <= EV_ROLE;
      rc_evt.command_opcode_field <= OCF_SWAP;
      rc_evt.status <= LM_SW_STATUS;
      rc_evt.hdl <= '0;
      rc_evt.pol <= POL_NONE;
      rc_evt.addr <= LM_SW_ADDR;
      rc_evt.role <= LM_SW_NEWROLE;
    end else begin
      rc_pend <= 1'b0;
    end
  end

  // -------------------------------------------
  // link manager policy query
  // -------------------------------------------
  // the manager samples once per request and keeps the answer,
  // so a later write never changes a request already running
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      LM_QRY_DONE <= 1'b0;
      LM_QRY_ALLOW <= 1'b0;
    end else begin
      LM_QRY_DONE <= LM_QRY_VALID; // see RULE15
      LM_QRY_ALLOW <= 1'b0;
      if (LM_QRY_VALID && LM_QRY_HDL < 12'(NCONN)) begin
        // each bit stands alone, any mix is honoured
        LM_QRY_ALLOW <= |(pol_tab[LM_QRY_HDL[$clog2(NCONN)-1:0]] &
                          LM_QRY_MODE); // see RULE10 RULE13 RULE14
      end
    end
  end

  // -------------------------------------------
  // register port
  // -------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      err_id <= ERR_ID_RST;
      err_cmd <= ERR_CMD_RST;
      err_busy <= ERR_BUSY_RST;
    end else if (REG_WR) begin
      case (REG_ADDR)
        REG_ERR_ID: err_id <= REG_WDATA[7:0];
        REG_ERR_CMD: err_cmd <= REG_WDATA[7:0];
        REG_ERR_BUSY: err_busy <= REG_WDATA[7:0];
        default: begin
        end
      endcase
    end
  end

  // unmapped offsets read zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_ERR_ID: REG_RDATA <= {24'h000000, err_id};
        REG_ERR_CMD: REG_RDATA <= {24'h000000, err_cmd};
        REG_ERR_BUSY: REG_RDATA <= {24'h000000, err_busy};
        REG_STATE: REG_RDATA <= 32'({LM_CONN_UP, rs_state == RS_WAIT});
        default: REG_RDATA <= '0;
      endcase
    end else begin
      REG_RDATA <= '0;
    end
  end

  // -------------------------------------------
  // checks
  // -------------------------------------------
  // every check runs on the one clock and sleeps during reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // a role swap taken while no other swap is pending
  sequence s_swap_in;
    take && CMD.command_opcode_field == OCF_SWAP && rs_state == RS_IDLE;
  endsequence

  // a role swap taken while one is still in flight
  sequence s_swap_busy;
    take && CMD.command_opcode_field == OCF_SWAP && rs_state == RS_WAIT;
  endsequence

  // a successful status event on the event port
  sequence s_status_ok;
    EVT_VALID && EVT.kind == EV_STATUS && EVT.status == ST_OK;
  endsequence

  // a policy write to a live slot, straight away read back
  sequence s_write_then_read;
    take && CMD.command_opcode_field == OCF_PWR && slot_ok ##1
    take && CMD.command_opcode_field == OCF_PRD && CMD.hdl == $past(CMD.hdl);
  endsequence

  // the host hears of every accepted swap one cycle later
  a_swap_status: assert property (s_swap_in |=> s_status_ok) // see RULE4
    else $error("role swap not acknowledged by status");

  // the link manager gets the peer the host named
  a_swap_request: assert property ( // see RULE1
    s_swap_in |=> LM_SW_REQ && LM_SW_ADDR == $past(CMD.addr))
    else $error("role swap not passed to link manager");

  // a second swap is refused and never reaches the manager
  a_swap_refused: assert property ( // see RULE17
    s_swap_busy |=> EVT_VALID && EVT.kind == EV_STATUS &&
    EVT.status == $past(err_busy) && !LM_SW_REQ)
    else $error("overlapping role swap not refused");

  // completion of a swap is only ever the role change event
  a_no_cmpl_swap: assert property ( // see RULE6
    EVT_VALID && EVT.kind == EV_CMPL |-> EVT.command_opcode_field != OCF_SWAP)
    else $error("complete event for role swap");

  // the remote host is told in the same cycle as ours
  a_role_both: assert property ( // see RULE5
    EVT_VALID && EVT.kind == EV_ROLE |-> RMT_NOTIFY)
    else $error("role change not sent to remote host");

  // and the remote host is never told of a change that did not happen
  a_notify_only: assert property ( // see RULE5
    RMT_NOTIFY |-> EVT_VALID && EVT.kind == EV_ROLE)
    else $error("remote notice without role change");

  // the role change names the swap and the peer that was asked for
  a_role_echo: assert property ( // see RULE5
    EVT_VALID && EVT.kind == EV_ROLE |->
    EVT.command_opcode_field == OCF_SWAP && EVT.addr == LM_SW_ADDR)
    else $error("role change names wrong peer");

  // only the two legal role codes go to the manager
  a_role_map: assert property ( // see RULE2
    LM_SW_REQ |-> LM_SW_ROLE == ROLE_MASTER || LM_SW_ROLE == ROLE_SLAVE)
    else $error("bad role byte to link manager");

  // a policy read completes next cycle and echoes its id
  a_read_cmpl: assert property ( // see RULE18
    take && CMD.command_opcode_field == OCF_PRD |=>
    EVT_VALID && EVT.kind == EV_CMPL && EVT.hdl == $past(CMD.hdl))
    else $error("policy read not completed with id");

  // a policy write completes next cycle and echoes its id
  a_write_cmpl: assert property ( // see RULE19
    take && CMD.command_opcode_field == OCF_PWR |=>
    EVT_VALID && EVT.kind == EV_CMPL && EVT.hdl == $past(CMD.hdl))
    else $error("policy write not completed with id");

  // reserved policy bits never come back set
  a_rsvd_zero: assert property ( // see RULE12
    EVT_VALID && EVT.kind == EV_CMPL |-> (EVT.pol & ~POL_USED) == 16'h0000)
    else $error("reserved policy bits returned set");

  // reserved ids are never reported as success by a policy read
  a_bad_id: assert property ( // see RULE9
    take && CMD.command_opcode_field == OCF_PRD && CMD.hdl >= HDL_RSVD |=> EVT.status != ST_OK)
    else $error("reserved id accepted");

  // a word written is the word read at the very next command
  a_write_read: assert property ( // see RULE8
    s_write_then_read |=> EVT.pol == ($past(CMD.pol, 2) & POL_USED))
    else $error("written policy not read back");

  // a dropped link on the top slot falls back to the all-off policy
  a_pol_default: assert property ( // see RULE11
    !LM_CONN_UP[NCONN-1] |=> pol_tab[NCONN-1] == POL_NONE[3:0])
    else $error("dropped slot kept its policy");

  // the manager is never left waiting for an answer
  a_query_time: assert property (LM_QRY_VALID |=> LM_QRY_DONE) // see RULE14
    else $error("policy query unanswered");
endmodule
`default_nettype wire

// ==== bench/lprs_lm_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// link manager stand-in for role swaps
// ----------------------------------------
module lprs_lm_model import lprs_pkg::*; (
  input wire logic clk, // bench clock
  input wire logic sys_rst, // sync reset, high
  input wire logic sw_req, // swap request pulse
  input wire logic [7:0] sw_role, // role asked for
  input wire logic [7:0] lag, // cycles before the swap ends
  output logic sw_done, // swap finished pulse
  output logic [7:0] sw_status, // outcome, valid with done
  output logic [7:0] sw_newrole // role now held
);
  logic [7:0] cnt; // cycles left
  logic busy; // swap under way
  logic [7:0] role_q; // role captured at request
  // answers promptly or slowly; status lines flip after done so stale data shows
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= 1'h0;
      cnt <= 8'h0;
      role_q <= 8'h0;
      sw_done <= 1'h0;
      sw_status <= 8'h5a;
      sw_newrole <= 8'ha5;
    end else begin
      sw_done <= 1'h0;
      if (sw_done) begin
        sw_status <= ~sw_status;
        sw_newrole <= ~sw_newrole;
      end
      if (sw_req) begin
        busy <= 1'h1;
        cnt <= lag;
        role_q <= sw_role;
      end else if (busy && cnt != 8'h0) begin
        cnt <= cnt - 8'h1;
      end else if (busy) begin
        busy <= 1'h0;
        sw_done <= 1'h1;
        sw_status <= ST_OK;
        sw_newrole <= role_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/lprs_top_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((ex) !== (got)) begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
  end
module lprs_top_test import lprs_pkg::*;;
  typedef struct packed {lprs_evt_s e; logic [104:0] m;} lprs_exp_s;
  localparam logic [104:0] mk_stat = ~105'h0 << 84; // kind, opcode, status
  localparam logic [104:0] mk_wr = ~105'h0 << 72; // plus echoed id
  localparam logic [104:0] mk_cmpl = ~105'h0 << 56; // plus policy word
  logic clk = 1'h0, sys_rst = 1'h1, cmd_valid = 1'h0, qry_valid = 1'h0;
  logic reg_wr = 1'h0, reg_rd = 1'h0, rd_prev = 1'h0, a_x;
  logic cmd_ready, evt_valid, sw_req, sw_done, rmt, qry_done, qry_allow;
  lprs_cmd_s cmd = '0;
  lprs_evt_s evt;
  lprs_exp_s cur;
  logic [3:0] conn_up = 4'hf, qry_mode = 4'h0, reg_addr = 4'h0;
  logic [11:0] qry_hdl = 12'h0, h;
  logic [47:0] sw_addr, adr = 48'h0;
  logic [7:0] sw_role, sw_status, sw_newrole, rl = 8'h0, lag = 8'h1;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, r_x;
  logic [15:0] w, pol_exp [4] = '{default: 16'h0};
  logic [11:0] bad_ids [3] = '{12'h3, 12'heff, 12'hf00};
  lprs_exp_s eq[$];
  logic aq[$];
  logic [31:0] rq[$];
  int bad_count = 0, tests_run = 0, cyc = 0;
  lprs_top #(.NCONN(4)) dut_u (.CLK(clk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid),
    .CMD(cmd), .CMD_READY(cmd_ready), .EVT_VALID(evt_valid), .EVT(evt),
    .LM_CONN_UP(conn_up), .LM_SW_REQ(sw_req), .LM_SW_ADDR(sw_addr), .LM_SW_ROLE(sw_role),
    .LM_SW_DONE(sw_done), .LM_SW_STATUS(sw_status), .LM_SW_NEWROLE(sw_newrole),
    .RMT_NOTIFY(rmt), .LM_QRY_VALID(qry_valid), .LM_QRY_HDL(qry_hdl),
    .LM_QRY_MODE(qry_mode), .LM_QRY_DONE(qry_done), .LM_QRY_ALLOW(qry_allow),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));
  lprs_lm_model lm_u (.clk(clk), .sys_rst(sys_rst), .sw_req(sw_req), .sw_role(sw_role),
    .lag(lag), .sw_done(sw_done), .sw_status(sw_status), .sw_newrole(sw_newrole));
  // ----------------------------------------
  // clock, drivers and notes
  // ----------------------------------------
  always #5 clk = ~clk;
  // note an expected event; addr and role come from the current swap
  function automatic void ex(lprs_kind_e k, logic [9:0] o, logic [7:0] st, logic [11:0] hd,
                             logic [15:0] p, logic [104:0] m);
    eq.push_back('{e: '{k, o, st, hd, p, adr, rl}, m: m});
  endfunction
  // holds the command until ready is seen high at a falling edge, then through the next rising edge
  task automatic send(input logic [9:0] o, input logic [11:0] hd, input logic [15:0] p);
    cmd <= '{o, hd, adr, rl, p};
    cmd_valid <= 1'h1;
    do @(negedge clk); while (cmd_ready !== 1'h1);
    @(posedge clk);
  endtask
  task automatic idle;
    cmd_valid <= 1'h0;
    @(posedge clk);
  endtask
  // one-cycle policy query; caller lets the edge pass
  task automatic ask(input logic [11:0] hd, input int k);
    qry_valid <= 1'h1;
    qry_hdl <= hd;
    qry_mode <= 4'h1 << k;
    aq.push_back(pol_exp[hd][k]);
  endtask
  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    if (!wr) rq.push_back(d);
    @(posedge clk);
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // output watcher, sampled mid-cycle so edge updates have landed
  // ----------------------------------------
  always @(negedge clk) begin
    if (evt_valid === 1'h1) begin
      cur = eq.size() ? eq.pop_front() : lprs_exp_s'{e: '0, m: '1}; // spare one mismatches
      `CHK("event", cur.e & cur.m, evt & cur.m)
      if (cur.e.kind === EV_ROLE) `CHK("notify", 1'h1, rmt)
    end
    if (qry_done === 1'h1) begin
      a_x = aq.pop_front();
      `CHK("allow", a_x, qry_allow)
    end
    if (rd_prev) begin
      r_x = rq.pop_front();
      `CHK("rdata", r_x, reg_rdata)
    end
    if (sw_req === 1'h1) `CHK("swap", {adr, rl}, {sw_addr, sw_role})
    rd_prev = reg_rd;
  end
  // hang guard, run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(53170));
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    ex(EV_CMPL, OCF_PRD, ST_OK, 12'h2, 16'h0000, mk_cmpl);
    send(OCF_PRD, 12'h2, 16'h0);
    idle();
    reg_op(1'h0, REG_ERR_ID, {24'h0, ERR_ID_RST});
    reg_op(1'h0, REG_ERR_CMD, {24'h0, ERR_CMD_RST});
    reg_op(1'h0, REG_ERR_BUSY, {24'h0, ERR_BUSY_RST});
    reg_op(1'h0, REG_STATE, 32'h1e);
    reg_op(1'h0, 4'h9, 32'h0);
    reg_op(1'h1, REG_ERR_ID, 32'h3c);
    reg_wr <= 1'h0;
    // random words, reserved bits must read back clear
    for (int i = 0; i < 8; i++) begin
      h = 12'($urandom_range(3)); // only live acl slots
      w = 16'($urandom);
      pol_exp[h] = w & 16'h000f;
      // write and read back to back, the read must see the new word
      ex(EV_CMPL, OCF_PWR, ST_OK, h, 16'h0, mk_wr);
      ex(EV_CMPL, OCF_PRD, ST_OK, h, pol_exp[h], mk_cmpl);
      send(OCF_PWR, h, w);
      send(OCF_PRD, h, 16'h0);
      idle();
      for (int k = 0; k < 4; k++) begin
        ask(h, k);
        @(posedge clk);
      end
      qry_valid <= 1'h0;
    end
    @(posedge clk);
    // query taken on the write's own edge still sees the old word
    ask(12'h1, 0);
    ex(EV_CMPL, OCF_PWR, ST_OK, 12'h1, 16'h0, mk_wr);
    send(OCF_PWR, 12'h1, pol_exp[1] ^ 16'h0001);
    qry_valid <= 1'h0;
    pol_exp[1] = pol_exp[1] ^ 16'h0001;
    idle();
    ask(12'h1, 0);
    @(posedge clk);
    qry_valid <= 1'h0;
    // slot dropped, top valid id and first reserved id are all refused
    conn_up <= 4'h7;
    foreach (bad_ids[i]) begin
      ex(EV_CMPL, OCF_PRD, 8'h3c, bad_ids[i], 16'h0, mk_wr);
      send(OCF_PRD, bad_ids[i], 16'h0);
    end
    ex(EV_STATUS, 10'h3ff, ERR_CMD_RST, 12'h0, 16'h0, mk_stat);
    send(10'h3ff, 12'h0, 16'h0);
    idle();
    // master then slave, prompt then slow partner with a refused overlap
    for (int j = 0; j < 2; j++) begin
      rl = j ? ROLE_SLAVE : ROLE_MASTER;
      adr = {16'($urandom), 32'($urandom)}; // a connected peer
      lag <= j ? 8'h7 : 8'h1;
      ex(EV_STATUS, OCF_SWAP, ST_OK, 12'h0, 16'h0, mk_stat);
      if (j) ex(EV_STATUS, OCF_SWAP, ERR_BUSY_RST, 12'h0, 16'h0, mk_stat);
      ex(EV_ROLE, OCF_SWAP, ST_OK, 12'h0, 16'h0, ~105'h0);
      send(OCF_SWAP, 12'h0, 16'h0);
      if (j) send(OCF_SWAP, 12'h0, 16'h0);
      idle();
      repeat (14) @(posedge clk);
    end
    `CHK("leftover", 0, eq.size() + aq.size() + rq.size())
    final_report();
  end
endmodule
`default_nettype wire
